// ==== core/bsc_sequencer.sv ====
// Start-up and commutation sequencer of a sensorless three-phase motor drive.
// Assumes comparator trips and the oscillator clock are synchronous to
// ref_clk; the oscillator is seen as a level whose rising edge advances.
`timescale 1ns/1ps
`include "bsc_defs.svh"

module bsc_sequencer (
  input  wire logic                  ref_clk,        // 40 MHz system clock
  input  wire logic                  resetn,         // Async reset, active low
  input  wire logic                  align_trip,     // Align-time comparator tripped
  input  wire logic                  ramp_trip,      // Ramp-time comparator tripped
  input  wire logic                  osc_clk,        // Commutation oscillator clock
  input  wire bsc_pkg::bsc_sense_type sense_in,      // Phase sense comparator levels
  output bsc_pkg::bsc_drive_type     drive,          // Bridge gate drives
  output bsc_pkg::bsc_sense_type     sample_sel,     // One-hot undriven phase select
  output logic                       sampler_en,     // Back-EMF sampler enable
  output logic                       ramp_src_en,    // Ramp source on control node
  output logic                       sampled_level,  // Selected phase sense level, low outside run
  output bsc_pkg::bsc_mode_type      mode            // Current start-up mode
);
  import bsc_pkg::*;

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  function automatic bsc_drive_type drive_of(input bsc_state_type s);
    unique case (s)
      BSC_ST_R: drive_of = `BSC_DRIVE_R;
      BSC_ST_A: drive_of = `BSC_DRIVE_A;
      BSC_ST_B: drive_of = `BSC_DRIVE_B;
      BSC_ST_C: drive_of = `BSC_DRIVE_C;
      BSC_ST_D: drive_of = `BSC_DRIVE_D;
      BSC_ST_E: drive_of = `BSC_DRIVE_E;
      BSC_ST_F: drive_of = `BSC_DRIVE_F;
      default:  drive_of = `BSC_DRIVE_OFF;
    endcase
  endfunction

  function automatic bsc_sense_type sel_of(input bsc_state_type s);
    unique case (s)
      BSC_ST_A, BSC_ST_D: sel_of = `BSC_SEL_B;
      BSC_ST_B, BSC_ST_E: sel_of = `BSC_SEL_A;
      BSC_ST_C, BSC_ST_F: sel_of = `BSC_SEL_C;
      default:            sel_of = `BSC_SEL_NONE;
    endcase
  endfunction

  function automatic bsc_state_type succ(input bsc_state_type s);
    unique case (s)
      BSC_ST_A: succ = BSC_ST_B;
      BSC_ST_B: succ = BSC_ST_C;
      BSC_ST_C: succ = BSC_ST_D;
      BSC_ST_D: succ = BSC_ST_E;
      BSC_ST_E: succ = BSC_ST_F;
      default:  succ = BSC_ST_A;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Oscillator edge
  // ----------------------------------------------------------------
  logic          osc_prev;
  logic          osc_rise;
  bsc_state_type state;
  bsc_state_type next_state;
  bsc_mode_type  next_mode;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_clk;
    end
  end

  assign osc_rise = osc_clk & ~osc_prev;

  // ----------------------------------------------------------------
  // Start-up mode
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    unique case (mode)
      BSC_ALIGN: if (align_trip) next_mode = BSC_RAMP;
      BSC_RAMP:  if (ramp_trip)  next_mode = BSC_RUN;
      BSC_RUN:   next_mode = BSC_RUN;
      default:   next_mode = BSC_ALIGN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= BSC_ALIGN;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Commutation state
  // ----------------------------------------------------------------
  // Entry to ramp waits for an oscillator edge, so state R holds
  // until the first real commutation clock.
  always_comb begin
    next_state = state;
    if (mode == BSC_ALIGN) begin
      next_state = BSC_ST_R;
    end else if (osc_rise) begin
      next_state = succ(state);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= BSC_ST_R;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      drive      <= `BSC_DRIVE_R;
      sample_sel <= `BSC_SEL_NONE;
    end else begin
      drive      <= drive_of(next_state);
      sample_sel <= sel_of(next_state);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sampler_en  <= 1'b0;
      ramp_src_en <= 1'b0;
    end else begin
      sampler_en  <= (next_mode == BSC_RUN);
      ramp_src_en <= (next_mode == BSC_RAMP);
    end
  end

  // Sampled level is meaningless outside run; held low there.
  // Uses the registered select, which matches the drive word now on
  // the bridge; the next-state select would read a still driven leg.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sampled_level <= 1'b0;
    end else begin
      sampled_level <= (mode == BSC_RUN) &&
                       |(sense_in & sample_sel);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_align_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode == BSC_ALIGN) |=> (mode != BSC_ALIGN) || (drive == `BSC_DRIVE_R))
    else $error("align drive wrong");

  chk_align_exit: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode == BSC_ALIGN) && align_trip |=> (mode == BSC_RAMP))
    else $error("align did not end on trip");

  chk_align_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode == BSC_ALIGN) && !align_trip |=> (mode == BSC_ALIGN))
    else $error("align left without trip");

  chk_ramp_step: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode != BSC_ALIGN) && osc_rise && (state == BSC_ST_F) |=> (state == BSC_ST_A))
    else $error("no wrap after F");

  chk_step_edge: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode != BSC_ALIGN) && !osc_rise |=> $stable(state))
    else $error("state moved without edge");

  chk_ramp_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode == BSC_RAMP) |-> ramp_src_en && !sampler_en)
    else $error("ramp flags wrong");

  chk_run_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode == BSC_RUN) |=> (mode == BSC_RUN) [*3])
    else $error("run mode left");

  chk_run_sense: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode == BSC_RUN) |-> sampler_en && !ramp_src_en)
    else $error("run flags wrong");

  chk_sel_undriven: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state != BSC_ST_R) |->
      ($countones(sample_sel) == 1) &&
      ((sample_sel & drive[5:3]) == `BSC_SEL_NONE) &&
      ((sample_sel & ~drive[2:0]) == `BSC_SEL_NONE))
    else $error("sample select wrong");

  chk_one_pair: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode != BSC_ALIGN) && (state != BSC_ST_R) |=>
      ($countones(drive[5:3]) == 1) && ($countones(~drive[2:0]) == 1) &&
      ((drive[5:3] & ~drive[2:0]) == `BSC_SEL_NONE))
    else $error("drive pair wrong");

  chk_no_realign: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode == BSC_RUN) |=> (state != BSC_ST_R))
    else $error("run returned to align");

  chk_ramp_start: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode != BSC_ALIGN) && osc_rise && (state == BSC_ST_R) |=> (state == BSC_ST_A))
    else $error("ramp did not start at A");

  chk_idle_select: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == BSC_ST_R) |-> (sample_sel == `BSC_SEL_NONE) && !sampled_level)
    else $error("select active in state R");

endmodule

// ==== core/bsc_defs.svh ====
// Timing-free constants of the start-up commutation sequencer.
// Assumes inclusion by the package and the core module only.
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

// Drive word order: {low_a, low_b, low_c, high_a_n, high_b_n, high_c_n}
// High-side bits are active low; a 0 turns the switch on.
`define BSC_DRIVE_W     6
`define BSC_DRIVE_OFF   6'h07
`define BSC_DRIVE_R     6'h12
`define BSC_DRIVE_A     6'h0b
`define BSC_DRIVE_B     6'h0d
`define BSC_DRIVE_C     6'h25
`define BSC_DRIVE_D     6'h26
`define BSC_DRIVE_E     6'h16
`define BSC_DRIVE_F     6'h13

// One-hot sample selects {phase_a, phase_b, phase_c}
`define BSC_SEL_W       3
`define BSC_SEL_NONE    3'h0
`define BSC_SEL_A       3'h4
`define BSC_SEL_B       3'h2
`define BSC_SEL_C       3'h1

`endif

// ==== core/bsc_pkg.sv ====
// Types of the start-up commutation sequencer.
// Assumes bsc_defs.svh sits in the include path.
`include "bsc_defs.svh"

package bsc_pkg;

  typedef enum logic [1:0] {
    BSC_ALIGN,
    BSC_RAMP,
    BSC_RUN
  } bsc_mode_type;

  typedef enum logic [2:0] {
    BSC_ST_R,
    BSC_ST_A,
    BSC_ST_B,
    BSC_ST_C,
    BSC_ST_D,
    BSC_ST_E,
    BSC_ST_F
  } bsc_state_type;

  typedef struct packed {
    logic low_drive_phase_a;
    logic low_drive_phase_b;
    logic low_drive_phase_c;
    logic high_drive_phase_a_n;
    logic high_drive_phase_b_n;
    logic high_drive_phase_c_n;
  } bsc_drive_type;

  typedef struct packed {
    logic sense_phase_a;
    logic sense_phase_b;
    logic sense_phase_c;
  } bsc_sense_type;

endpackage

// ==== testbench/bsc_bridge_model.sv ====
// Behavioural bridge and motor seen through the phase sense dividers.
// Assumes the bench sets the back-EMF level of the floating phase.
`timescale 1ns/1ps

module bsc_bridge_model (
  input  wire logic                   emf_level,  // Back-EMF level of the floating phase
  input  wire bsc_pkg::bsc_drive_type drive,      // Gate drives from the sequencer
  output bsc_pkg::bsc_sense_type      sense_in    // Divided phase levels
);
  import bsc_pkg::*;

  // ------------------------------------------
  // Phase legs
  // ------------------------------------------
  // High side pulls the leg up, low side down; a leg with both off floats
  // on the back-EMF, so a wrong sample pick reads a driven level instead.
  function automatic logic leg(input logic lo, input logic hi_n, input logic emf);
    return !hi_n ? 1'b1 : (lo ? 1'b0 : emf);
  endfunction

  always_comb begin
    sense_in.sense_phase_a = leg(drive.low_drive_phase_a, drive.high_drive_phase_a_n, emf_level);
    sense_in.sense_phase_b = leg(drive.low_drive_phase_b, drive.high_drive_phase_b_n, emf_level);
    sense_in.sense_phase_c = leg(drive.low_drive_phase_c, drive.high_drive_phase_c_n, emf_level);
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench of the start-up commutation sequencer.
// Assumes the bridge model answers combinationally to the drive word.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; $display("wrong value at %0t ns: %h vs %h", $time, (a), (e)); end end

module tb_top;
  import bsc_pkg::*;
  typedef struct packed {logic [5:0] drv; logic [2:0] sel;} bsc_row_type;

  logic          ref_clk, resetn, align_trip, ramp_trip, osc_clk, emf_level;
  logic          sampler_en, ramp_src_en, sampled_level;
  bsc_sense_type sense_in, sample_sel;
  bsc_drive_type drive;
  bsc_mode_type  mode;
  int            err_total, checked, cycles;
  bsc_row_type   rows [6] = '{'{6'h0b, 3'h2}, '{6'h0d, 3'h4}, '{6'h25, 3'h1},
                              '{6'h26, 3'h2}, '{6'h16, 3'h4}, '{6'h13, 3'h1}};

  bsc_sequencer dut (.ref_clk(ref_clk), .resetn(resetn), .align_trip(align_trip),
    .ramp_trip(ramp_trip), .osc_clk(osc_clk), .sense_in(sense_in), .drive(drive),
    .sample_sel(sample_sel), .sampler_en(sampler_en), .ramp_src_en(ramp_src_en),
    .sampled_level(sampled_level), .mode(mode));
  bsc_bridge_model model (.emf_level(emf_level), .drive(drive), .sense_in(sense_in));

  // ------------------------------------------
  // Clock, timeout and verdict
  // ------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Whole run is under two hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      summarize();
    end
  end

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One oscillator period, high one cycle, then low for at least three
  task automatic step();
    @(posedge ref_clk) osc_clk <= 1'b1;
    @(posedge ref_clk) osc_clk <= 1'b0;
    tick(2);
  endtask

  task automatic align_pulse();
    @(posedge ref_clk) align_trip <= 1'b1;
    @(posedge ref_clk) align_trip <= 1'b0;
    tick(2);
  endtask

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    {resetn, align_trip, ramp_trip, osc_clk, emf_level} = 5'h00;
    tick(12);
    @(posedge ref_clk) resetn <= 1'b1;
    tick(2);
    align_pulse();
    `CHK(mode, BSC_RAMP)
    `CHK(drive, 6'h12)
    // Two full turns prove the wrap from F to A
    for (int i = 0; i < 12; i++) begin
      step();
      `CHK(drive, rows[i % 6].drv)
      `CHK(sample_sel, rows[i % 6].sel)
      `CHK({sampler_en, ramp_src_en, sampled_level}, 3'b010)
    end
    tick(8);
    `CHK(drive, rows[5].drv)
    @(posedge ref_clk) ramp_trip <= 1'b1;
    @(posedge ref_clk) ramp_trip <= 1'b0;
    tick(2);
    `CHK(mode, BSC_RUN)
    `CHK({sampler_en, ramp_src_en}, 2'b10)
    for (int i = 0; i < 6; i++) begin
      step();
      `CHK(drive, rows[i].drv)
      for (int v = 0; v < 2; v++) begin
        @(posedge ref_clk) emf_level <= v[0];
        tick(3);
        `CHK(sampled_level, v[0])
      end
    end
    @(posedge ref_clk) {align_trip, ramp_trip} <= 2'b11;
    tick(4);
    `CHK(mode, BSC_RUN)
    // Reset in mid-run, with the ramp comparator left tripped
    @(posedge ref_clk) {resetn, align_trip} <= 2'b00;
    tick(3);
    `CHK(mode, BSC_ALIGN)
    `CHK(drive, 6'h12)
    `CHK({sample_sel, sampler_en, ramp_src_en, sampled_level}, 6'h00)
    @(posedge ref_clk) resetn <= 1'b1;
    step();
    step();
    tick(4);
    `CHK(mode, BSC_ALIGN)
    `CHK(drive, 6'h12)
    @(posedge ref_clk) ramp_trip <= 1'b0;
    align_pulse();
    `CHK(mode, BSC_RAMP)
    step();
    `CHK(drive, rows[0].drv)
    summarize();
  end
endmodule
